// ### src/sstr_top.sv
// Self-test supervisor reaction logic with AXI4-Lite register access
`timescale 1ns/10ps
module sstr_top
	import sstr_pkg::*;
#(
	parameter longint INTERVAL = DIAG_INTERVAL_CYC
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Field input test
	input wire logic input_test_active,
	input wire logic [27:0] input_levels,
	// Memory and supply tests
	input wire logic volatile_memory_fail,
	input wire logic program_memory_fail,
	input wire logic supply_hi_under,
	input wire logic supply_hi_over,
	input wire logic supply_lo_under,
	input wire logic supply_lo_over,
	// Relays: commanded state, feedback, test done
	input wire logic [NGRP-1:0] relay_cmd,
	input wire logic [NGRP-1:0] relay_feedback,
	input wire logic relay_unknown_fail,
	input wire logic [NGRP-1:0] relay_tested,
	input wire logic interval_unknown_fail,
	// Car stopped at floor
	input wire logic car_at_stop,
	// Outputs to the safety chain; safety_circuit_output and safety_brake_output high means closed
	output logic safety_circuit_output,
	output logic safety_brake_output,
	output logic [NGRP-1:0] relay_force_open,
	output logic stop_request,
	output logic replace_unit,
	output logic [7:0] err_code,
	output logic [7:0] err_subcode,
	output logic irq,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ------------------------------------------------------------
	// Fault detection
	// ------------------------------------------------------------
	logic [NGRP-1:0] expired;
	genvar g;
	generate
		for (g = 0; g < NGRP; g++)
		begin : gen_wd
			sstr_interval #(.LIMIT(INTERVAL)) u_wd (
				.mclk(mclk),
				.rst(rst),
				.tested(relay_tested[g]),
				.expired(expired[g])
			);
		end
	endgenerate

	// Expected value during the test is 0 on every tested input
	wire logic in_odd_fail = input_test_active && |(input_levels & IN_MASK_ODD);
	wire logic in_high_fail = input_test_active && |(input_levels & IN_MASK_HIGH);
	wire logic supply_fail = supply_hi_under | supply_hi_over | supply_lo_under
		| supply_lo_over;
	wire logic [NGRP-1:0] fb_mismatch = relay_cmd ^ relay_feedback;
	wire logic relfb_fail = (|fb_mismatch) | relay_unknown_fail;
	wire logic mem_fail = volatile_memory_fail | program_memory_fail;
	wire logic intv_fail = (|expired) | interval_unknown_fail;

	logic [31:0] ctrl_reg;
	logic err_reset;
	wire logic lvl1 = ctrl_reg[CTRL_LVL1];
	wire logic lvl2 = ctrl_reg[CTRL_LVL2];
	wire logic lvl3 = ctrl_reg[CTRL_LVL3];

	// Severe faults open both outputs; take the first of several by fixed priority
	wire logic sev3 = in_odd_fail | in_high_fail | mem_fail | supply_fail | relfb_fail
		| lvl3;

	function automatic logic [7:0] grp_sub(input logic [NGRP-1:0] v);
		if (v[0])
			return SUB_GRP_CIRC;
		else if (v[1])
			return SUB_GRP_AUX;
		else if (v[2])
			return SUB_GRP_DOOR;
		else if (v[3])
			return SUB_GRP_BRAKE;
		else
			return SUB_NONE;
	endfunction

	logic [7:0] new_code, new_sub;
	always_comb
	begin
		new_code = ERR_NONE;
		new_sub = SUB_NONE;
		if (in_odd_fail)
		begin
			new_code = ERR_INPUT;
			new_sub = SUB_IN_ODD;
		end
		else if (in_high_fail)
		begin
			new_code = ERR_INPUT;
			new_sub = SUB_IN_HIGH;
		end
		else if (volatile_memory_fail)
			new_code = ERR_VRAM;
		else if (program_memory_fail)
			new_code = ERR_PROM;
		else if (supply_fail)
		begin
			new_code = ERR_SUPPLY;
			if (supply_hi_under)
				new_sub = SUB_SUP_HI_UNDER;
			else if (supply_hi_over)
				new_sub = SUB_SUP_HI_OVER;
			else if (supply_lo_under)
				new_sub = SUB_SUP_LO_UNDER;
			else
				new_sub = SUB_SUP_LO_OVER;
		end
		else if (relfb_fail)
		begin
			new_code = ERR_RELFB;
			new_sub = grp_sub(fb_mismatch);
		end
		else if (lvl3)
			new_code = ERR_LVL3;
		else if (lvl2)
			new_code = ERR_LVL2;
		else if (intv_fail)
		begin
			new_code = ERR_INTERVAL;
			new_sub = grp_sub(expired);
		end
		else if (lvl1)
			new_code = ERR_LVL1;
	end

	// ------------------------------------------------------------
	// Latched reaction
	// ------------------------------------------------------------
	// Reaction only escalates, but car_at_stop drops stop_reg; err_reset releases all but a live fault wins over it
	logic circ_open_reg, brake_open_reg, stop_reg, repl_reg;
	logic [NGRP-1:0] force_reg;
	wire logic hold = !err_reset;
	wire logic first = (err_code == ERR_NONE) || err_reset;

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			circ_open_reg <= 1'b0;
			brake_open_reg <= 1'b0;
			stop_reg <= 1'b0;
			repl_reg <= 1'b0;
			force_reg <= '0;
			err_code <= ERR_NONE;
			err_subcode <= SUB_NONE;
		end
		else
		begin
			circ_open_reg <= (circ_open_reg && hold) || sev3 || lvl2;
			brake_open_reg <= (brake_open_reg && hold) || sev3;
			stop_reg <= ((stop_reg && hold) || intv_fail || lvl1) && !car_at_stop;
			repl_reg <= (repl_reg && hold) || mem_fail;
			force_reg <= (force_reg & {NGRP{hold}}) | expired;
			if (new_code != ERR_NONE && first)
			begin
				err_code <= new_code;
				err_subcode <= new_sub;
			end
			else if (err_reset)
			begin
				err_code <= ERR_NONE;
				err_subcode <= SUB_NONE;
			end
		end
	end

	assign safety_circuit_output = !circ_open_reg;
	assign safety_brake_output = !brake_open_reg;
	assign stop_request = stop_reg;
	assign replace_unit = repl_reg;
	assign relay_force_open = force_reg;

	// ------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------
	logic [NEV-1:0] stat_reg, en_reg, clr_bits;
	wire logic [NEV-1:0] ev = {lvl1 | lvl2 | lvl3, intv_fail, relfb_fail, supply_fail,
		mem_fail, in_odd_fail | in_high_fail};
	always_ff @(posedge mclk)
	begin
		if (rst)
			stat_reg <= '0;
		else
			stat_reg <= (stat_reg & ~clr_bits) | ev;
	end
	assign irq = |(stat_reg & en_reg);

	// ------------------------------------------------------------
	// AXI4-Lite slave
	// ------------------------------------------------------------
	logic aw_held, w_held;
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg;
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	wire logic aw_have = aw_held || (s_axi_awvalid && s_axi_awready);
	wire logic w_have = w_held || (s_axi_wvalid && s_axi_wready);
	wire logic [7:0] wr_addr = aw_held ? awaddr_reg : s_axi_awaddr;
	wire logic [31:0] wr_data = w_held ? wdata_reg : s_axi_wdata;
	wire logic do_wr = aw_have && w_have && !s_axi_bvalid;
	wire logic wr_map = wr_addr == ADDR_CTRL || wr_addr == ADDR_IRQ_EN
		|| wr_addr == ADDR_IRQ_CLR;
	assign err_reset = do_wr && wr_addr == ADDR_CTRL && s_axi_wstrb[0] && wr_data[CTRL_ERR_RESET];
	assign clr_bits = (do_wr && wr_addr == ADDR_IRQ_CLR && s_axi_wstrb[0])
		? wr_data[NEV-1:0] : '0;

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			ctrl_reg <= 32'h0;
			en_reg <= '0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
				awaddr_reg <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready)
				wdata_reg <= s_axi_wdata;
			aw_held <= aw_have && !do_wr;
			w_held <= w_have && !do_wr;
			if (do_wr)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
				if (wr_addr == ADDR_CTRL && s_axi_wstrb[0])
					ctrl_reg <= {28'h0, wr_data[3:1], 1'b0};
				if (wr_addr == ADDR_IRQ_EN && s_axi_wstrb[0])
					en_reg <= wr_data[NEV-1:0];
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	wire logic [31:0] rd_word =
		(s_axi_araddr == ADDR_CTRL) ? ctrl_reg :
		(s_axi_araddr == ADDR_ERR) ? {16'h0, err_code, err_subcode} :
		(s_axi_araddr == ADDR_IRQ_STAT) ? {26'h0, stat_reg} :
		(s_axi_araddr == ADDR_IRQ_EN) ? {26'h0, en_reg} :
		(s_axi_araddr == ADDR_OUT) ? {24'h0, force_reg, repl_reg, stop_reg,
			brake_open_reg, circ_open_reg} : 32'h0;
	wire logic rd_map = s_axi_araddr == ADDR_CTRL || s_axi_araddr == ADDR_ERR
		|| s_axi_araddr == ADDR_IRQ_STAT || s_axi_araddr == ADDR_IRQ_EN
		|| s_axi_araddr == ADDR_IRQ_CLR || s_axi_araddr == ADDR_OUT;
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_map ? RESP_OKAY : RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	input_opens_both_a: assert property (@(posedge mclk) disable iff (rst)
		in_odd_fail |=> !safety_circuit_output && !safety_brake_output)
		else $error("input test failure did not open outputs");
	input_sub_a: assert property (@(posedge mclk) disable iff (rst)
		(in_odd_fail && err_code == ERR_NONE) |=> err_subcode == SUB_IN_ODD)
		else $error("wrong input subcode");
	mem_replace_a: assert property (@(posedge mclk) disable iff (rst)
		mem_fail |=> replace_unit && !safety_brake_output)
		else $error("memory failure not flagged");
	supply_opens_a: assert property (@(posedge mclk) disable iff (rst)
		supply_fail |=> !safety_circuit_output && !safety_brake_output)
		else $error("supply failure did not open outputs");
	relay_mismatch_a: assert property (@(posedge mclk) disable iff (rst)
		(|fb_mismatch) |=> !safety_brake_output)
		else $error("relay mismatch did not open brake");
	interval_force_a: assert property (@(posedge mclk) disable iff (rst)
		expired[0] |=> relay_force_open[0] && err_code != ERR_NONE)
		else $error("expired interval did not force relays open");
	interval_sub_a: assert property (@(posedge mclk) disable iff (rst)
		(err_code == ERR_NONE && expired == 4'b0100 && !sev3 && !lvl2)
		|=> err_code == ERR_INTERVAL && err_subcode == SUB_GRP_DOOR)
		else $error("wrong interval subcode");
	level2_only_a: assert property (@(posedge mclk) disable iff (rst)
		(lvl2 && !sev3 && safety_brake_output) |=> !safety_circuit_output
		&& safety_brake_output)
		else $error("level 2 reaction wrong");
	latch_hold_a: assert property (@(posedge mclk) disable iff (rst)
		(err_code != ERR_NONE && !err_reset) |=> err_code == $past(err_code))
		else $error("error code changed without reset");

	trip_c: cover property (@(posedge mclk) disable iff (rst) $fell(safety_circuit_output));
	force_c: cover property (@(posedge mclk) disable iff (rst) $rose(|relay_force_open));
	clear_c: cover property (@(posedge mclk) disable iff (rst)
		err_reset && err_code != ERR_NONE);
endmodule

// ### src/sstr_pkg.sv
// Constants, types and register map of the safety self-test reaction block
package sstr_pkg;
	// Error codes (decimal number as BCD-like hex)
	localparam logic [7:0] ERR_NONE = 8'h00;
	localparam logic [7:0] ERR_LVL1 = 8'h30;
	localparam logic [7:0] ERR_LVL2 = 8'h31;
	localparam logic [7:0] ERR_LVL3 = 8'h32;
	localparam logic [7:0] ERR_INPUT = 8'h33;
	localparam logic [7:0] ERR_VRAM = 8'h34;
	localparam logic [7:0] ERR_SUPPLY = 8'h35;
	localparam logic [7:0] ERR_RELFB = 8'h36;
	localparam logic [7:0] ERR_PROM = 8'h37;
	localparam logic [7:0] ERR_INTERVAL = 8'h38;
	// Subcodes
	localparam logic [7:0] SUB_NONE = 8'h00;
	localparam logic [7:0] SUB_IN_ODD = 8'hA8;
	localparam logic [7:0] SUB_IN_HIGH = 8'h00;
	localparam logic [7:0] SUB_GRP_CIRC = 8'h01;
	localparam logic [7:0] SUB_GRP_AUX = 8'h02;
	localparam logic [7:0] SUB_GRP_DOOR = 8'h03;
	localparam logic [7:0] SUB_GRP_BRAKE = 8'h04;
	localparam logic [7:0] SUB_SUP_HI_UNDER = 8'h01;
	localparam logic [7:0] SUB_SUP_HI_OVER = 8'h02;
	localparam logic [7:0] SUB_SUP_LO_UNDER = 8'h03;
	localparam logic [7:0] SUB_SUP_LO_OVER = 8'h04;
	// Input test mask: odd 03..17, and 18..24, 26, 27
	localparam logic [27:0] IN_MASK_ODD = 28'h002AAA8;
	localparam logic [27:0] IN_MASK_HIGH = 28'hDFC0000;
	// Relay groups
	localparam int NGRP = 4;
	// Diagnostic interval, in ms, and cycles at 100 MHz
	localparam int CLK_MHZ = 100;
	localparam int DIAG_INTERVAL_MS = 1000;
	localparam longint DIAG_INTERVAL_CYC = longint'(DIAG_INTERVAL_MS) * 1000 * CLK_MHZ;
	// Register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_ERR = 8'h04;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
	localparam logic [7:0] ADDR_IRQ_EN = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_CLR = 8'h10;
	localparam logic [7:0] ADDR_OUT = 8'h14;
	// Control bits
	localparam int CTRL_ERR_RESET = 0;
	localparam int CTRL_LVL1 = 1;
	localparam int CTRL_LVL2 = 2;
	localparam int CTRL_LVL3 = 3;
	// Event bits
	localparam int EV_INPUT = 0;
	localparam int EV_MEM = 1;
	localparam int EV_SUPPLY = 2;
	localparam int EV_RELFB = 3;
	localparam int EV_INTERVAL = 4;
	localparam int EV_LEVEL = 5;
	localparam int NEV = 6;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {ST_RUN, ST_STOP_PENDING, ST_TRIPPED} sstr_state_t;
endpackage

// ### src/sstr_interval.sv
// Diagnostic interval watchdog for one relay group
`timescale 1ns/10ps
module sstr_interval
	import sstr_pkg::*;
#(
	parameter longint LIMIT = DIAG_INTERVAL_CYC
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Test activity
	input wire logic tested,
	// Expiry pulse
	output logic expired
);
	logic [39:0] count_reg;
	wire logic at_limit = (count_reg >= 40'(LIMIT - 1));

	always_ff @(posedge mclk)
	begin
		if (rst || tested || at_limit)
			count_reg <= 40'h0;
		else
			count_reg <= count_reg + 40'h1;
	end

	// Restart after expiry so the group is re-tested before clearing again
	assign expired = at_limit && !tested;

	counter_bound_a: assert property (@(posedge mclk) disable iff (rst)
		count_reg < 40'(LIMIT)) else $error("interval counter ran past limit");
endmodule

// ### dv/sstr_field.sv
// Field-side model: relay feedback contacts, relay test pulses, 24-V inputs
`timescale 1ns/10ps
module sstr_field
	import sstr_pkg::*;
(
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Fault injection from the bench
	input wire logic [NGRP-1:0] fb_bad,
	input wire logic [NGRP-1:0] test_en,
	input wire logic [27:0] stuck,
	// Relay side
	input wire logic [NGRP-1:0] relay_cmd,
	output logic [NGRP-1:0] relay_feedback,
	output logic [NGRP-1:0] relay_tested,
	// Input side
	output logic [27:0] input_levels
);
	logic [4:0] tick_reg;
	// Forced-guided contacts follow the coil unless a welded contact is injected
	assign relay_feedback = relay_cmd ^ fb_bad;
	assign input_levels = stuck;
	// Every 20 cycles, well inside the 50-cycle interval used in simulation
	assign relay_tested = (tick_reg == 5'h00) ? test_en : 4'h0;
	always_ff @(posedge mclk)
	begin
		if (rst || tick_reg == 5'h13)
			tick_reg <= 5'h00;
		else
			tick_reg <= tick_reg + 5'h01;
	end
endmodule

// ### dv/sstr_top_tb.sv
// Self-checking bench for the self-test reaction block
`timescale 1ns/10ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; $display("ERROR %0t: got %h expected %h", $time, a, e); end end
module sstr_top_tb
	import sstr_pkg::*;
;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic mclk, rst, ita, vmf, pmf, ruf, iuf, car, sco, sbo, stp, rpl, irq;
	logic [3:0] sup, cmd, fbb, ten, fb, tst, fo;
	logic [27:0] stuck, lv;
	logic [7:0] ec, es, awaddr, araddr;
	logic [31:0] wdata, rdata, rd;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [1:0] bresp, rresp, rsp;
	int fails, checks;
	int ibit[6] = '{3, 17, 18, 24, 26, 27};
	// ----------------------------------------
	// Design and field model
	// ----------------------------------------
	sstr_top #(.INTERVAL(50)) i_sstr_top (.mclk(mclk), .rst(rst), .input_test_active(ita),
		.input_levels(lv), .volatile_memory_fail(vmf), .program_memory_fail(pmf),
		.supply_hi_under(sup[0]), .supply_hi_over(sup[1]), .supply_lo_under(sup[2]),
		.supply_lo_over(sup[3]), .relay_cmd(cmd), .relay_feedback(fb), .relay_unknown_fail(ruf),
		.relay_tested(tst), .interval_unknown_fail(iuf), .car_at_stop(car),
		.safety_circuit_output(sco), .safety_brake_output(sbo), .relay_force_open(fo),
		.stop_request(stp), .replace_unit(rpl), .err_code(ec), .err_subcode(es), .irq(irq),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	sstr_field i_sstr_field (.mclk(mclk), .rst(rst), .fb_bad(fbb), .test_en(ten), .stuck(stuck),
		.relay_cmd(cmd), .relay_feedback(fb), .relay_tested(tst), .input_levels(lv));
	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do
		begin
			@(posedge mclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1);
		rsp = bresp;
	endtask
	task automatic axr(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do
		begin
			@(posedge mclk);
			if (arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1);
		rd = rdata;
		rsp = rresp;
	endtask
	task automatic trip(input logic [7:0] c, input logic ci, input logic br);
		repeat (3) @(posedge mclk);
		`CHK(ec, c)
		`CHK(sco, ci)
		`CHK(sbo, br)
	endtask
	// Error reset; live faults must be removed first or they re-latch
	task automatic clr();
		axw(ADDR_CTRL, 32'h00000001);
		repeat (2) @(posedge mclk);
		`CHK(ec, ERR_NONE)
		`CHK({sco, sbo, fo, stp, rpl}, 8'hC0)
	endtask
	task automatic give_verdict();
		if (fails == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	initial
	begin
		repeat (20000) @(posedge mclk);
		fails++;
		give_verdict();
	end
	initial
	begin
		{rst, ita, vmf, pmf, ruf, iuf, car} = 7'h40;
		{sup, fbb, stuck, awaddr, araddr, wdata} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h05;
		cmd = 4'h5;
		ten = 4'hF;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		`CHK({sco, sbo, fo, stp, rpl, ec, es}, 24'hC00000)
		for (int i = 0; i < 6; i++)
		begin
			axr(8'(4 * i));
			`CHK({rsp, rd}, {RESP_OKAY, 32'h00000000})
		end
		axr(8'h18);
		`CHK({rsp, rd}, {RESP_SLVERR, 32'h00000000})
		axw(ADDR_ERR, 32'h0000FFFF);
		`CHK(rsp, RESP_SLVERR)
		// Untested bits and inactive test must not trip
		stuck <= 28'hFFFFFFF;
		trip(ERR_NONE, 1'b1, 1'b1);
		ita <= 1'b1;
		stuck <= 28'h2000004;
		trip(ERR_NONE, 1'b1, 1'b1);
		for (int i = 0; i < 6; i++)
		begin
			stuck <= 28'h1 << ibit[i];
			trip(ERR_INPUT, 1'b0, 1'b0);
			`CHK(es, (i < 2) ? SUB_IN_ODD : SUB_IN_HIGH)
			stuck <= 28'h0;
			clr();
		end
		stuck <= 28'h0000200;
		trip(ERR_INPUT, 1'b0, 1'b0);
		stuck <= 28'h0;
		vmf <= 1'b1;
		repeat (5) @(posedge mclk);
		axr(ADDR_ERR);
		`CHK(rd, 32'h000033A8)
		vmf <= 1'b0;
		clr();
		axw(ADDR_IRQ_EN, 32'h1 << EV_MEM);
		vmf <= 1'b1;
		trip(ERR_VRAM, 1'b0, 1'b0);
		`CHK({rpl, irq}, 2'b11)
		axw(ADDR_IRQ_EN, 32'h0);
		@(posedge mclk);
		`CHK(irq, 1'b0)
		axr(ADDR_IRQ_STAT);
		`CHK(rd[EV_MEM], 1'b1)
		vmf <= 1'b0;
		axw(ADDR_IRQ_EN, 32'h1 << EV_MEM);
		@(posedge mclk);
		`CHK(irq, 1'b1)
		axw(ADDR_IRQ_CLR, 32'h1 << EV_MEM);
		@(posedge mclk);
		`CHK(irq, 1'b0)
		clr();
		pmf <= 1'b1;
		trip(ERR_PROM, 1'b0, 1'b0);
		`CHK(rpl, 1'b1)
		pmf <= 1'b0;
		clr();
		for (int i = 0; i < 4; i++)
		begin
			sup <= 4'h1 << i;
			trip(ERR_SUPPLY, 1'b0, 1'b0);
			`CHK(es, 8'(i + 1))
			sup <= 4'h0;
			clr();
		end
		for (int i = 0; i < 5; i++)
		begin
			fbb <= (i < 4) ? 4'h1 << i : 4'h0;
			ruf <= (i == 4);
			trip(ERR_RELFB, 1'b0, 1'b0);
			fbb <= 4'h0;
			ruf <= 1'b0;
			clr();
		end
		// Starving one group of tests at a time, then the unclassified case
		for (int i = 0; i < 5; i++)
		begin
			ten <= (i < 4) ? ~(4'h1 << i) : 4'hF;
			iuf <= (i == 4);
			repeat (80) @(posedge mclk);
			`CHK({ec, es, stp}, {ERR_INTERVAL, (i < 4) ? 8'(i + 1) : SUB_NONE, 1'b1})
			if (i < 4)
				`CHK(fo[i], 1'b1)
			car <= 1'b1;
			repeat (2) @(posedge mclk);
			`CHK(stp, 1'b0)
			car <= 1'b0;
			ten <= 4'hF;
			iuf <= 1'b0;
			repeat (25) @(posedge mclk);
			clr();
		end
		for (int i = 1; i < 4; i++)
		begin
			axw(ADDR_CTRL, 32'h1 << i);
			trip(ERR_LVL1 + 8'(i - 1), i < 2, i < 3);
			if (i == 1)
				`CHK(stp, 1'b1)
			axw(ADDR_CTRL, 32'h0);
			clr();
		end
		give_verdict();
	end
endmodule
